/* File: src/sfpe_defines.svh */
`ifndef SFPE_DEFINES_SVH
`define SFPE_DEFINES_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define SFPE_OP_UNLK 8'h06
`define SFPE_OP_RDSR 8'h05
`define SFPE_OP_QPI 8'h38
`define SFPE_OP_QPW 8'h32
`define SFPE_OP_SMALL 8'h20
`define SFPE_OP_MID 8'h52
`define SFPE_OP_LARGE 8'hD8
`define SFPE_OP_WHOLE_A 8'hC7
`define SFPE_OP_WHOLE_B 8'h60

// ----------------------------------------
// Frame framing
// ----------------------------------------
`define SFPE_OP_BITS 6'h08
`define SFPE_HDR_BITS 6'h20
`define SFPE_STEP_SPI 6'h01
`define SFPE_STEP_QPI 6'h04
`define SFPE_LAST_IDX 8'hFF

// ----------------------------------------
// Region masks and protection
// ----------------------------------------
`define SFPE_MASK_SMALL 24'hFFF000
`define SFPE_MASK_MID 24'hFF8000
`define SFPE_MASK_LARGE 24'hFF0000
`define SFPE_BLK_MSB 18
`define SFPE_BLK_LSB 16
`define SFPE_BP_START1 3'h7
`define SFPE_BP_START2 3'h6
`define SFPE_BP_START3 3'h4
`define SFPE_BP_STARTX 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFPE_CLK_MHZ 25
`define SFPE_US_PER_MS 1000
`define SFPE_T_PAGE_US 800
`define SFPE_T_SMALL_MS 30
`define SFPE_T_MID_MS 100
`define SFPE_T_LARGE_MS 200
`define SFPE_T_WHOLE_MS 1500

`endif

/* File: src/sfpe_pkg.sv */
package sfpe_pkg;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_WALK = 2'b01,
      S_RUN = 2'b10
   } sfpe_state_t;

   typedef enum logic [2:0] {
      RG_BYTE = 3'b000,
      RG_SMALL = 3'b001,
      RG_MID = 3'b010,
      RG_LARGE = 3'b011,
      RG_WHOLE = 3'b100
   } sfpe_region_t;

   typedef struct packed {
      logic req;
      logic erase;
      sfpe_region_t region;
      logic [23:0] addr;
      logic [7:0] data;
   } sfpe_arr_req_t;

endpackage

/* File: src/sfpe_sync.sv */
module sfpe_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic hold_q;
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               meta_q <= RST_VAL[g];
               hold_q <= RST_VAL[g];
            end else begin
               meta_q <= d_i[g];
               hold_q <= meta_q;
            end
         end
         assign q_o[g] = hold_q;
      end
   endgenerate
endmodule

/* File: src/sfpe_timer.sv */
module sfpe_timer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Control
   input wire logic load_i,
   input wire logic [31:0] cycles_i,
   output logic done_o
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic done_d;

   always_comb begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (load_i) begin
         cnt_d = cycles_i;
      end else if (cnt_q != 32'h0) begin
         cnt_d = cnt_q - 32'h1;
         done_d = (cnt_q == 32'h1);
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= 32'h0;
         done_o <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_o <= done_d;
      end
   end
endmodule

/* File: src/sfpe_top.sv */
// Behaviour
// - Quad write frame: 32h opcode, 24-bit address, then data bytes
// - Up to 256 data bytes taken, one nibble per clock on lines 3..0
// - Quad write accepted only while the write unlock latch is set
// - Quad write exists only in single-line command mode
// - Bytes past the page end wrap to the start of the same page
// - Quad write runs only if select rises on a byte boundary
// - Beyond 256 bytes, the last 256 received are programmed
// - Opcode 20h plus three address bytes erases a 4 KB sector
// - Opcode 52h plus three address bytes erases a 32 KB block
// - Opcode D8h plus three address bytes erases a 64 KB block
// - Whole erase is opcode C7h or 60h alone, no address
// - Erase sets every bit of the chosen region to one
// - Erase accepted only after a write unlock command set the latch
// - Region erases run only if select rises right after the address
// - Whole erase runs only if select rises right after the opcode
// - Self-timed cycle starts right at the completing select rise
// - Status reads are answered while a cycle runs
// - Write unlock latch clears before the cycle finishes
// - Region erase refused when its region is protected
// - Whole erase runs only when all protect level bits are zero
// - Erases are accepted in four-line command mode as well
`include "sfpe_defines.svh"

module sfpe_top #(
   parameter int unsigned PAGE_CYC = `SFPE_T_PAGE_US * `SFPE_CLK_MHZ,
   parameter int unsigned SMALL_CYC =
      `SFPE_T_SMALL_MS * `SFPE_US_PER_MS * `SFPE_CLK_MHZ,
   parameter int unsigned MID_CYC =
      `SFPE_T_MID_MS * `SFPE_US_PER_MS * `SFPE_CLK_MHZ,
   parameter int unsigned LARGE_CYC =
      `SFPE_T_LARGE_MS * `SFPE_US_PER_MS * `SFPE_CLK_MHZ,
   parameter int unsigned WHOLE_CYC =
      `SFPE_T_WHOLE_MS * `SFPE_US_PER_MS * `SFPE_CLK_MHZ
) (
   // System
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Serial link
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic [3:0] dq_i,
   output logic [3:0] dq_o,
   output logic [3:0] dq_oe_o,
   // Protection level pins
   input wire logic [3:0] protect_level_i,
   // Status
   output logic cycle_running_flag_o,
   output logic write_unlock_latch_o,
   output logic four_line_mode_o,
   // Array access
   output sfpe_pkg::sfpe_arr_req_t arr_req_o
);
   import sfpe_pkg::*;

   // ----------------------------------------
   // Link side: command capture on sck rising
   // ----------------------------------------
   logic fst_q;
   logic [7:0] op_q, op_d;
   logic [23:0] addr_q, addr_d;
   logic [5:0] hdr_q, hdr_d, hdr_b, step;
   logic extra_q, extra_d, half_q, half_d, seen_q, seen_d;
   logic qpi_q, qpi_d, qpi_now, tog_q, tog_d;
   logic [3:0] nib_q, nib_d;
   logic [7:0] ptr_q, ptr_d;
   logic [7:0] buf_q [256];
   logic [7:0] buf_d [256];
   logic [255:0] vld_q, vld_d;
   logic [7:0] stat_l;

   function automatic logic has_addr(input logic [7:0] op);
      return op == `SFPE_OP_QPW || op == `SFPE_OP_SMALL ||
         op == `SFPE_OP_MID || op == `SFPE_OP_LARGE;
   endfunction

   // First-edge marker, forced while select is high
   always_ff @(posedge sck_i or posedge cs_n_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fst_q <= 1'b1;
      end else if (cs_n_i) begin
         fst_q <= 1'b1;
      end else begin
         fst_q <= 1'b0;
      end
   end

   always_comb begin
      // Mode change lands at the next frame start; no edge exists before
      qpi_now = qpi_q | (fst_q && op_q == `SFPE_OP_QPI &&
         hdr_q == `SFPE_OP_BITS && !extra_q);
      step = qpi_now ? `SFPE_STEP_QPI : `SFPE_STEP_SPI;
      hdr_b = fst_q ? 6'h00 : hdr_q;
      qpi_d = qpi_now;
      tog_d = fst_q ? ~tog_q : tog_q;
      op_d = op_q;
      addr_d = addr_q;
      hdr_d = hdr_b;
      extra_d = fst_q ? 1'b0 : extra_q;
      half_d = fst_q ? 1'b0 : half_q;
      seen_d = fst_q ? 1'b0 : seen_q;
      nib_d = nib_q;
      ptr_d = ptr_q;
      buf_d = buf_q;
      vld_d = (fst_q && !stat_l[0]) ? 256'h0 : vld_q;
      if (hdr_b < `SFPE_OP_BITS) begin
         op_d = qpi_now ? {op_q[3:0], dq_i} : {op_q[6:0], dq_i[0]};
         hdr_d = hdr_b + step;
      end else if (hdr_b < `SFPE_HDR_BITS && has_addr(op_q)) begin
         addr_d = qpi_now ? {addr_q[19:0], dq_i}
            : {addr_q[22:0], dq_i[0]};
         hdr_d = hdr_b + step;
         if (hdr_d == `SFPE_HDR_BITS) begin
            ptr_d = addr_d[7:0];
         end
      end else if (op_q == `SFPE_OP_QPW && !qpi_now) begin
         if (!half_d) begin
            nib_d = dq_i;
            half_d = 1'b1;
         end else begin
            // Buffer frozen while a cycle reads it
            if (!stat_l[0]) begin
               buf_d[ptr_q] = {nib_q, dq_i};
               vld_d[ptr_q] = 1'b1;
            end
            ptr_d = ptr_q + 8'h01;
            half_d = 1'b0;
            seen_d = 1'b1;
         end
      end else if (op_q != `SFPE_OP_RDSR) begin
         extra_d = 1'b1;
      end
   end

   always_ff @(posedge sck_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         op_q <= 8'h00;
         addr_q <= 24'h000000;
         hdr_q <= 6'h00;
         extra_q <= 1'b0;
         half_q <= 1'b0;
         seen_q <= 1'b0;
         qpi_q <= 1'b0;
         tog_q <= 1'b0;
         nib_q <= 4'h0;
         ptr_q <= 8'h00;
         vld_q <= 256'h0;
      end else begin
         op_q <= op_d;
         addr_q <= addr_d;
         hdr_q <= hdr_d;
         extra_q <= extra_d;
         half_q <= half_d;
         seen_q <= seen_d;
         qpi_q <= qpi_d;
         tog_q <= tog_d;
         nib_q <= nib_d;
         ptr_q <= ptr_d;
         vld_q <= vld_d;
      end
   end

   // Data storage needs no reset: only entries marked valid are used
   always_ff @(posedge sck_i) begin
      buf_q <= buf_d;
   end

   property p_no_quad_write_in_qpi;
      @(posedge sck_i) disable iff (!reset_n_i)
         (qpi_q && !fst_q) |-> !seen_q;
   endproperty
   a_no_quad_write_in_qpi: assert property (p_no_quad_write_in_qpi)
      else $error("quad write data taken in four-line mode");

   // ----------------------------------------
   // Link side: status answer on sck falling
   // ----------------------------------------
   logic [3:0] dqo_d, dqoe_d;
   logic [2:0] ocnt_q, ocnt_d;
   logic rdsr_on;

   always_comb begin
      rdsr_on = !fst_q && op_q == `SFPE_OP_RDSR && hdr_q >= `SFPE_OP_BITS;
      dqo_d = 4'h0;
      dqoe_d = 4'h0;
      ocnt_d = ocnt_q;
      if (rdsr_on) begin
         if (qpi_q) begin
            dqo_d = ocnt_q[2] ? stat_l[3:0] : stat_l[7:4];
            dqoe_d = 4'hF;
            ocnt_d = ocnt_q + 3'h4;
         end else begin
            dqo_d = {2'h0, stat_l[3'h7 - ocnt_q], 1'b0};
            dqoe_d = 4'h2;
            ocnt_d = ocnt_q + 3'h1;
         end
      end
   end

   always_ff @(negedge sck_i or posedge cs_n_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dq_o <= 4'h0;
         dq_oe_o <= 4'h0;
         ocnt_q <= 3'h0;
      end else if (cs_n_i) begin
         dq_o <= 4'h0;
         dq_oe_o <= 4'h0;
         ocnt_q <= 3'h0;
      end else begin
         dq_o <= dqo_d;
         dq_oe_o <= dqoe_d;
         ocnt_q <= ocnt_d;
      end
   end

   // ----------------------------------------
   // Crossings
   // ----------------------------------------
   logic cs_s, tog_s, qpi_s;
   logic [3:0] bp_s;
   logic run_q, lat_q;

   sfpe_sync #(.W(7), .RST_VAL(7'h40)) u_in_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .d_i({cs_n_i, tog_q, qpi_q, protect_level_i}),
      .q_o({cs_s, tog_s, qpi_s, bp_s})
   );

   sfpe_sync #(.W(8), .RST_VAL(8'h00)) u_stat_sync (
      .clk_i(sck_i),
      .reset_n_i(reset_n_i),
      .d_i({2'h0, bp_s, lat_q, run_q}),
      .q_o(stat_l)
   );

   // ----------------------------------------
   // System side: commit and self-timed cycle
   // ----------------------------------------
   sfpe_state_t state_q, state_d;
   logic cs_prev_q, seen_tog_q, seen_tog_d, run_d, lat_d, t_done, tload;
   logic [7:0] idx_q, idx_d;
   logic [15:0] page_q, page_d;
   logic [31:0] tcyc, ecyc;
   logic [23:0] emask;
   sfpe_region_t rgn;
   sfpe_arr_req_t req_q, req_d;
   logic rise, commit, at_op, at_hdr, is_whole, is_region, prot_hit;
   logic ok_unlk, ok_erase, ok_whole, ok_prog;
   logic [2:0] bp_start;

   sfpe_timer u_timer (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .load_i(tload),
      .cycles_i(tcyc),
      .done_o(t_done)
   );

   always_comb begin
      unique case (bp_s)
         4'h1: bp_start = `SFPE_BP_START1;
         4'h2: bp_start = `SFPE_BP_START2;
         4'h3: bp_start = `SFPE_BP_START3;
         default: bp_start = `SFPE_BP_STARTX;
      endcase
      prot_hit = (bp_s != 4'h0) &&
         (addr_q[`SFPE_BLK_MSB:`SFPE_BLK_LSB] >= bp_start);
      rgn = RG_SMALL;
      emask = `SFPE_MASK_SMALL;
      ecyc = 32'(SMALL_CYC);
      is_region = 1'b1;
      unique case (op_q)
         `SFPE_OP_MID: begin
            rgn = RG_MID;
            emask = `SFPE_MASK_MID;
            ecyc = 32'(MID_CYC);
         end
         `SFPE_OP_LARGE: begin
            rgn = RG_LARGE;
            emask = `SFPE_MASK_LARGE;
            ecyc = 32'(LARGE_CYC);
         end
         `SFPE_OP_SMALL: is_region = 1'b1;
         default: is_region = 1'b0;
      endcase
      is_whole = op_q == `SFPE_OP_WHOLE_A || op_q == `SFPE_OP_WHOLE_B;
      // Link registers are still while select is high: sck is stopped
      rise = cs_s && !cs_prev_q;
      commit = rise && (tog_s != seen_tog_q) && state_q == S_IDLE;
      at_op = hdr_q == `SFPE_OP_BITS && !extra_q;
      at_hdr = hdr_q == `SFPE_HDR_BITS && !extra_q;
      ok_unlk = commit && at_op && op_q == `SFPE_OP_UNLK;
      ok_erase = commit && lat_q && at_hdr && is_region && !prot_hit;
      ok_whole = commit && lat_q && at_op && is_whole && bp_s == 4'h0;
      ok_prog = commit && lat_q && op_q == `SFPE_OP_QPW && seen_q &&
         !half_q && !extra_q && !prot_hit;
   end

   always_comb begin
      seen_tog_d = rise ? tog_s : seen_tog_q;
      state_d = state_q;
      idx_d = idx_q;
      lat_d = lat_q;
      run_d = run_q;
      page_d = page_q;
      req_d = '0;
      tload = 1'b0;
      tcyc = 32'(PAGE_CYC);
      unique case (state_q)
         S_IDLE: begin
            if (ok_unlk) begin
               lat_d = 1'b1;
            end
            if (ok_erase || ok_whole) begin
               req_d.req = 1'b1;
               req_d.erase = 1'b1;
               req_d.region = ok_whole ? RG_WHOLE : rgn;
               req_d.addr = ok_whole ? 24'h000000 : (addr_q & emask);
               tload = 1'b1;
               tcyc = ok_whole ? 32'(WHOLE_CYC) : ecyc;
               lat_d = 1'b0;
               run_d = 1'b1;
               state_d = S_RUN;
            end else if (ok_prog) begin
               page_d = addr_q[23:8];
               idx_d = 8'h00;
               lat_d = 1'b0;
               run_d = 1'b1;
               state_d = S_WALK;
            end
         end
         S_WALK: begin
            if (vld_q[idx_q]) begin
               req_d.req = 1'b1;
               req_d.region = RG_BYTE;
               req_d.addr = {page_q, idx_q};
               req_d.data = buf_q[idx_q];
            end
            idx_d = idx_q + 8'h01;
            if (idx_q == `SFPE_LAST_IDX) begin
               tload = 1'b1;
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            if (t_done) begin
               run_d = 1'b0;
               state_d = S_IDLE;
            end
         end
         default: begin
            run_d = 1'b0;
            state_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= S_IDLE;
         cs_prev_q <= 1'b1;
         seen_tog_q <= 1'b0;
         idx_q <= 8'h00;
         lat_q <= 1'b0;
         run_q <= 1'b0;
         page_q <= 16'h0000;
         req_q <= '0;
         four_line_mode_o <= 1'b0;
      end else begin
         state_q <= state_d;
         cs_prev_q <= cs_s;
         seen_tog_q <= seen_tog_d;
         idx_q <= idx_d;
         lat_q <= lat_d;
         run_q <= run_d;
         page_q <= page_d;
         req_q <= req_d;
         four_line_mode_o <= qpi_s;
      end
   end

   assign cycle_running_flag_o = run_q;
   assign write_unlock_latch_o = lat_q;
   assign arr_req_o = req_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_unlock_first;
      @(posedge clk_i) disable iff (!reset_n_i)
         (state_q == S_IDLE && state_d != S_IDLE) |-> lat_q;
   endproperty
   a_unlock_first: assert property (p_unlock_first)
      else $error("cycle started without write unlock latch");

   property p_prog_unlock;
      @(posedge clk_i) disable iff (!reset_n_i)
         $rose(state_q == S_WALK) |-> $past(lat_q) && !lat_q;
   endproperty
   a_prog_unlock: assert property (p_prog_unlock)
      else $error("quad write started without latch");

   property p_start_now;
      @(posedge clk_i) disable iff (!reset_n_i)
         $rose(run_q) |-> $past(cs_s) && !$past(cs_prev_q);
   endproperty
   a_start_now: assert property (p_start_now)
      else $error("cycle did not start at select rise");

   property p_flag_falls;
      @(posedge clk_i) disable iff (!reset_n_i)
         (state_q == S_RUN && t_done) |=> !run_q && state_q == S_IDLE;
   endproperty
   a_flag_falls: assert property (p_flag_falls)
      else $error("running flag outlived the cycle");

   property p_flag_holds;
      @(posedge clk_i) disable iff (!reset_n_i)
         (state_q != S_IDLE) |-> run_q;
   endproperty
   a_flag_holds: assert property (p_flag_holds)
      else $error("running flag low during cycle");

   property p_latch_clear;
      @(posedge clk_i) disable iff (!reset_n_i)
         run_q |-> !lat_q;
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("unlock latch set during cycle");

   property p_whole_unprot;
      @(posedge clk_i) disable iff (!reset_n_i)
         (arr_req_o.req && arr_req_o.region == RG_WHOLE) |->
            $past(bp_s) == 4'h0 && $past(hdr_q) == `SFPE_OP_BITS;
   endproperty
   a_whole_unprot: assert property (p_whole_unprot)
      else $error("whole erase under protection or bad framing");

   property p_region_unprot;
      @(posedge clk_i) disable iff (!reset_n_i)
         (arr_req_o.req && arr_req_o.erase &&
            arr_req_o.region != RG_WHOLE) |-> !$past(prot_hit);
   endproperty
   a_region_unprot: assert property (p_region_unprot)
      else $error("protected region erased");

   property p_addr_framing;
      @(posedge clk_i) disable iff (!reset_n_i)
         (arr_req_o.req && arr_req_o.erase &&
            arr_req_o.region != RG_WHOLE) |->
            $past(hdr_q) == `SFPE_HDR_BITS && !$past(extra_q);
   endproperty
   a_addr_framing: assert property (p_addr_framing)
      else $error("region erase without exact address end");

   property p_region_align;
      @(posedge clk_i) disable iff (!reset_n_i)
         (arr_req_o.req && arr_req_o.region == RG_MID) |->
            arr_req_o.addr[14:0] == 15'h0000;
   endproperty
   a_region_align: assert property (p_region_align)
      else $error("mid region address not aligned");

   property p_byte_bound;
      @(posedge clk_i) disable iff (!reset_n_i)
         $rose(state_q == S_WALK) |-> $past(seen_q) && !$past(half_q);
   endproperty
   a_byte_bound: assert property (p_byte_bound)
      else $error("quad write committed off a byte boundary");

   property p_same_page;
      @(posedge clk_i) disable iff (!reset_n_i)
         (arr_req_o.req && !arr_req_o.erase) |->
            arr_req_o.addr[23:8] == page_q;
   endproperty
   a_same_page: assert property (p_same_page)
      else $error("write left its page");
endmodule

/* File: tb/sfpe_host_model.sv */
module sfpe_host_model (
   // Link to the device
   output logic sck_o,
   output logic cs_n_o,
   output logic [3:0] dq_o,
   // Answer from the device
   input wire logic [3:0] dq_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Set by the bench once four-line mode is on; no way back
   logic qpi = 1'b0;

   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      dq_o = 4'h0;
   end

   // Clock stands low between frames; data moves while it is low
   task automatic put(input logic [3:0] v);
      dq_o = v;
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
   endtask

   task automatic start();
      cs_n_o = 1'b0;
      #32;
   endtask

   task automatic tx(input logic [7:0] b);
      if (qpi) begin
         put(b[7:4]);
         put(b[3:0]);
      end else begin
         for (int i = 7; i >= 0; i--) put({3'h0, b[i]});
      end
   endtask

   // Device drives on the falling edge, so sample at the rising one
   task automatic rx(output logic [7:0] b);
      b = 8'h00;
      for (int i = 0; i < (qpi ? 2 : 8); i++) begin
         dq_o = 4'h0;
         #32 sck_o = 1'b1;
         b = qpi ? {b[3:0], dq_i} : {b[6:0], dq_i[1]};
         #32 sck_o = 1'b0;
      end
   endtask

   // Gap long enough for the device to settle the frame
   task automatic stop();
      #32 cs_n_o = 1'b1;
      dq_o = ~dq_o;
      #200;
   endtask
endmodule

/* File: tb/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sfpe_pkg::*;

   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic sck, cs_n, run, latch, qmode;
   logic [3:0] dq, dqo, dqoe;
   logic [3:0] prot = 4'h0;
   sfpe_arr_req_t arr;
   sfpe_arr_req_t q[$];
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;

   always #20 clk_i = ~clk_i;

   sfpe_host_model host_u (.sck_o(sck), .cs_n_o(cs_n), .dq_o(dq),
      .dq_i(dqo));

   // Short cycle counts keep the run brief
   sfpe_top #(.PAGE_CYC(40), .SMALL_CYC(60), .MID_CYC(70),
      .LARGE_CYC(80), .WHOLE_CYC(90)) dut_u (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .sck_i(sck), .cs_n_i(cs_n),
      .dq_i(dq), .dq_o(dqo), .dq_oe_o(dqoe), .protect_level_i(prot),
      .cycle_running_flag_o(run), .write_unlock_latch_o(latch),
      .four_line_mode_o(qmode), .arr_req_o(arr));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (arr.req === 1'b1) q.push_back(arr);
      if (cycles == 40000) begin
         failures = failures + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Byte k/2 of the stream; byte 256 overwrites byte 0
   function automatic logic [3:0] nib(input int k);
      logic [7:0] d;
      d = (k / 2 == 256) ? 8'hC3 : 8'(k / 2);
      return k[0] ? d[3:0] : d[7:4];
   endfunction

   task automatic send(input logic [7:0] op, input logic [23:0] a,
      input int na, input int nn);
      host_u.start();
      host_u.tx(op);
      for (int i = 0; i < na; i++) host_u.tx(a[23-8*i -: 8]);
      for (int k = 0; k < nn; k++) host_u.put(nib(k));
      host_u.stop();
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (run === 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      chk("run done", 32'h0, run);
   endtask

   task automatic expect_op(input string nm, input logic ok,
      input sfpe_region_t rg, input logic [23:0] a);
      repeat (4) @(posedge clk_i);
      chk({nm, " run"}, ok, run);
      chk({nm, " reqs"}, ok, q.size());
      if (ok === 1'b1 && q.size() > 0) begin
         chk({nm, " region"}, rg, q[0].region);
         if (rg != RG_WHOLE) chk({nm, " addr"}, a, q[0].addr);
         chk({nm, " erase"}, 32'h1, q[0].erase);
         chk({nm, " latch"}, 32'h0, latch);
      end
      drain();
      q.delete();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_erase();
      logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
      sfpe_region_t rgs[5] = '{RG_SMALL, RG_MID, RG_LARGE, RG_WHOLE,
         RG_WHOLE};
      logic [23:0] m[5] = '{24'hFFF000, 24'hFF8000, 24'hFF0000, 24'h0,
         24'h0};
      send(8'h20, 24'h05ABCD, 3, 0);
      expect_op("locked", 1'b0, RG_SMALL, 24'h0);
      for (int i = 0; i < 5; i++) begin
         send(8'h06, 24'h0, 0, 0);
         send(ops[i], 24'h05ABCD, i < 3 ? 3 : 0, 0);
         expect_op("erase", 1'b1, rgs[i], 24'h05ABCD & m[i]);
      end
   endtask

   // Status poll while an erase runs
   task automatic t_status();
      logic [7:0] s;
      send(8'h06, 24'h0, 0, 0);
      chk("latch set", 32'h1, latch);
      send(8'h20, 24'h000000, 3, 0);
      host_u.start();
      host_u.tx(8'h05);
      host_u.rx(s);
      #8;
      chk("status oe", 32'h2, dqoe);
      host_u.stop();
      chk("status", 32'h01, s);
      chk("status off", 32'h0, dqoe);
      chk("status reqs", 32'h1, q.size());
      drain();
      q.delete();
   endtask

   task automatic t_frame();
      send(8'h06, 24'h0, 0, 0);
      send(8'h20, 24'h05ABCD, 3, 1);
      expect_op("extra bit", 1'b0, RG_SMALL, 24'h0);
      send(8'h20, 24'h05ABCD, 2, 0);
      expect_op("short", 1'b0, RG_SMALL, 24'h0);
      send(8'hC7, 24'h05ABCD, 1, 0);
      expect_op("whole long", 1'b0, RG_WHOLE, 24'h0);
      @(posedge clk_i);
      prot <= 4'h1;
      repeat (4) @(posedge clk_i);
      send(8'h20, 24'h071234, 3, 0);
      expect_op("protected", 1'b0, RG_SMALL, 24'h0);
      send(8'hC7, 24'h0, 0, 0);
      expect_op("whole prot", 1'b0, RG_WHOLE, 24'h0);
      send(8'h20, 24'h061234, 3, 0);
      expect_op("open", 1'b1, RG_SMALL, 24'h061000);
      @(posedge clk_i);
      prot <= 4'h0;
   endtask

   task automatic t_qpw();
      send(8'h06, 24'h0, 0, 0);
      send(8'h32, 24'h0312FF, 3, 4);
      drain();
      chk("wrap n", 32'h2, q.size());
      chk("wrap a0", 24'h031200, q[0].addr);
      chk("wrap d0", 8'h01, q[0].data);
      chk("wrap a1", 24'h0312FF, q[1].addr);
      chk("wrap kind", {1'b0, RG_BYTE}, {q[1].erase, q[1].region});
      q.delete();
      send(8'h32, 24'h0, 3, 2);
      expect_op("write locked", 1'b0, RG_BYTE, 24'h0);
      send(8'h06, 24'h0, 0, 0);
      send(8'h32, 24'h0, 3, 3);
      expect_op("odd nibble", 1'b0, RG_BYTE, 24'h0);
      send(8'h32, 24'h040000, 3, 514);
      drain();
      chk("over n", 32'h100, q.size());
      chk("over d0", 8'hC3, q[0].data);
      chk("over d255", 8'hFF, q[255].data);
      q.delete();
   endtask

   task automatic t_qpi();
      send(8'h38, 24'h0, 0, 0);
      host_u.qpi = 1'b1;
      send(8'h06, 24'h0, 0, 0);
      chk("mode", 32'h1, qmode);
      send(8'h52, 24'h01ABCD, 3, 0);
      expect_op("qpi erase", 1'b1, RG_MID, 24'h018000);
      send(8'h06, 24'h0, 0, 0);
      send(8'h32, 24'h0, 3, 2);
      expect_op("qpi write", 1'b0, RG_BYTE, 24'h0);
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_erase();
      t_status();
      t_frame();
      t_qpw();
      t_qpi();
      report_and_stop();
   end
endmodule
